// [hdl/qfc_pkg.sv]
/*
 * Shared constants and types for the quad flash command sequencer: widths,
 * command codes, pin-level timing as times and as REF_CLK cycle counts, and
 * the packed structs that carry requests and pin states.
 * Assumes a 100 MHz REF_CLK and a 32-bit module built from four byte lanes.
 */
// How it works
// - The sequencer always drives both pair selects together, treating the module as one 32-bit device.
// - Every command byte is copied into each selected byte lane, so a setup code 40H goes out as 40404040H.
// - A program sends the replicated setup code first and then a second write with the whole data word.
// - Lanes whose devices must stay idle get a zero byte instead of the command.
// - A program interval runs at least 10 us before the stop command that ends it.
// - An erase interval runs between 9.5 ms and 10.5 ms, aimed at the middle.
// - After any write the sequencer waits at least 6 us before it starts a read.
// - The programming supply is raised at least 1.0 us before a select goes active for program or erase.
// - The write strobe pulse sits wholly inside the select pulse, so the strobe defines the write.
package qfc_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int CNT_W = 21;
  localparam int SYNC_STAGES = 2;

  localparam logic [7:0] PROG_SETUP_CODE = 8'h40;

  // ************************************************************
  // Pin timing, as times and as cycle counts.
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_CS_NS = 20;
  localparam int T_WP_NS = 80;
  localparam int T_DH_NS = 10;
  localparam int T_WPH_NS = 20;
  localparam int T_ACC_NS = 120;
  localparam int T_VPEL_NS = 1000;
  localparam int T_WR_NS = 6000;
  localparam int T_DP_NS = 10000;
  localparam int T_DE_MIN_NS = 9500000;
  localparam int T_DE_MAX_NS = 10500000;
  localparam int T_DE_NOM_NS = (T_DE_MIN_NS + T_DE_MAX_NS) / 2;

  localparam int CS_CYC = (T_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DH_CYC = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VPEL_CYC = (T_VPEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DP_CYC = (T_DP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DE_MIN_CYC = (T_DE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DE_MAX_CYC = T_DE_MAX_NS / CLK_PERIOD_NS;
  localparam int DE_NOM_CYC = T_DE_NOM_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    QFC_OP_READ = 2'h0,
    QFC_OP_WRITE = 2'h1,
    QFC_OP_PROGRAM = 2'h2,
    QFC_OP_ERASE = 2'h3
  } qfc_op_e;

  typedef struct packed {
    qfc_op_e op;
    logic [LANES-1:0] lanes;
    logic [7:0] code;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } qfc_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic dout_oe;
    logic sel_n;
    logic we_n;
    logic oe_n;
    logic vpp;
  } qfc_pins_s;

endpackage

// [hdl/qfc_timer.sv]
/*
 * Down-counting interval timer used for every wait of the sequencer.
 * Assumes the loader waits for busy to fall before relying on a new count.
 */
`timescale 1ns/1ps
module qfc_timer #(
  parameter int W = 21
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic busy
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // A load of N keeps busy high for exactly N cycles after the load edge.
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != '0);

endmodule

// [hdl/qfc_sequencer.sv]
/*
 * Host-side sequencer for a 32-bit flash module made of four byte lanes in
 * two select pairs. Takes read, write, program and erase requests on a
 * valid/ready port and turns them into timed pin waveforms.
 * Assumes the board combines MODULE_DATA_LINES_O/_OE/_I into the shared bus
 * and switches the programming supply from VPP_ENABLE.
 */
`timescale 1ns/1ps
module qfc_sequencer #(
  parameter int ERASE_CYCLES = qfc_pkg::DE_NOM_CYC,
  parameter int ACCESS_CYCLES = qfc_pkg::ACC_CYC,
  parameter logic [7:0] PROG_STOP_CODE = 8'hc0,
  parameter logic [7:0] ERASE_STOP_CODE = 8'ha0
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire qfc_pkg::qfc_req_s CMD_REQ,
  output logic RD_VALID,
  output logic [qfc_pkg::DATA_W-1:0] RD_DATA,
  output logic [qfc_pkg::ADDR_W-1:0] WORD_ADDRESS_LINES,
  output logic [qfc_pkg::DATA_W-1:0] MODULE_DATA_LINES_O,
  output logic MODULE_DATA_LINES_OE,
  input wire logic [qfc_pkg::DATA_W-1:0] MODULE_DATA_LINES_I,
  output logic PAIR_SELECT_LOW_N,
  output logic PAIR_SELECT_HIGH_N,
  output logic PAIR_WRITE_STROBE_LOW_N,
  output logic PAIR_WRITE_STROBE_HIGH_N,
  output logic OUTPUT_ENABLE_N,
  output logic VPP_ENABLE
);

  localparam int CW = qfc_pkg::CNT_W;
  localparam int DW = qfc_pkg::DATA_W;

  if (ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << CW)) begin : g_erase_chk
    $error("ERASE_CYCLES out of timer range");
  end
  if (ACCESS_CYCLES < 1 || ACCESS_CYCLES + qfc_pkg::SYNC_STAGES >= (1 << CW)) begin : g_acc_chk
    $error("ACCESS_CYCLES out of timer range");
  end

  // ************************************************************
  // State and request hold.
  // ************************************************************
  typedef enum logic [10:0] {
    QFC_ST_IDLE = 11'h001,
    QFC_ST_VPP_WAIT = 11'h002,
    QFC_ST_WR_SETUP = 11'h004,
    QFC_ST_WR_PULSE = 11'h008,
    QFC_ST_WR_HOLD = 11'h010,
    QFC_ST_WR_GAP = 11'h020,
    QFC_ST_INTERVAL = 11'h040,
    QFC_ST_RD_WAIT = 11'h080,
    QFC_ST_RD_ACCESS = 11'h100,
    QFC_ST_RD_DONE = 11'h200,
    QFC_ST_DONE = 11'h400
  } qfc_state_e;

  qfc_state_e state_q, state_d;
  qfc_pkg::qfc_req_s req_q, req_d;
  logic [1:0] phase_q, phase_d;
  logic [DW-1:0] word_q, word_d;
  logic [DW-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  qfc_pkg::qfc_pins_s pins_q, pins_d;
  logic [DW-1:0] sync_q [qfc_pkg::SYNC_STAGES];
  logic tmr_load;
  logic [CW-1:0] tmr_value;
  logic tmr_busy;
  logic rec_load;
  logic rec_busy;

  qfc_timer #(.W(CW)) u_step_timer (
    .clk(REF_CLK),
    .rst(RESET),
    .load(tmr_load),
    .value(tmr_value),
    .busy(tmr_busy)
  );

  qfc_timer #(.W(CW)) u_recovery_timer (
    .clk(REF_CLK),
    .rst(RESET),
    .load(rec_load),
    .value(CW'(qfc_pkg::WR_CYC)),
    .busy(rec_busy)
  );

  // Copies the command byte into the selected lanes and zeroes the rest.
  function automatic logic [DW-1:0] lane_word(input logic [7:0] code,
                                              input logic [qfc_pkg::LANES-1:0] lanes);
    logic [DW-1:0] w;
    w = '0;
    for (int i = 0; i < qfc_pkg::LANES; i++) begin
      w[8*i +: 8] = lanes[i] ? code : 8'h00;
    end
    return w;
  endfunction

  // ************************************************************
  // Sequencing.
  // ************************************************************
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    phase_d = phase_q;
    word_d = word_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    tmr_load = 1'b0;
    tmr_value = '0;
    rec_load = 1'b0;
    case (state_q)
      QFC_ST_IDLE: begin
        if (CMD_VALID) begin
          req_d = CMD_REQ;
          phase_d = 2'h0;
          case (CMD_REQ.op)
            qfc_pkg::QFC_OP_READ: begin
              state_d = QFC_ST_RD_WAIT;
            end
            qfc_pkg::QFC_OP_WRITE: begin
              word_d = lane_word(CMD_REQ.code, CMD_REQ.lanes);
              state_d = QFC_ST_WR_SETUP;
              tmr_load = 1'b1;
              tmr_value = CW'(qfc_pkg::CS_CYC);
            end
            qfc_pkg::QFC_OP_PROGRAM: begin
              word_d = lane_word(qfc_pkg::PROG_SETUP_CODE, CMD_REQ.lanes);
              state_d = QFC_ST_VPP_WAIT;
              tmr_load = 1'b1;
              tmr_value = CW'(qfc_pkg::VPEL_CYC);
            end
            default: begin
              word_d = lane_word(CMD_REQ.code, CMD_REQ.lanes);
              state_d = QFC_ST_VPP_WAIT;
              tmr_load = 1'b1;
              tmr_value = CW'(qfc_pkg::VPEL_CYC);
            end
          endcase
        end
      end
      QFC_ST_VPP_WAIT: begin
        if (!tmr_busy) begin
          state_d = QFC_ST_WR_SETUP;
          tmr_load = 1'b1;
          tmr_value = CW'(qfc_pkg::CS_CYC);
        end
      end
      QFC_ST_WR_SETUP: begin
        if (!tmr_busy) begin
          state_d = QFC_ST_WR_PULSE;
          tmr_load = 1'b1;
          tmr_value = CW'(qfc_pkg::WP_CYC);
        end
      end
      QFC_ST_WR_PULSE: begin
        if (!tmr_busy) begin
          state_d = QFC_ST_WR_HOLD;
          tmr_load = 1'b1;
          tmr_value = CW'(qfc_pkg::DH_CYC);
        end
      end
      QFC_ST_WR_HOLD: begin
        if (!tmr_busy) begin
          state_d = QFC_ST_WR_GAP;
          tmr_load = 1'b1;
          tmr_value = CW'(qfc_pkg::WPH_CYC);
          rec_load = 1'b1;
        end
      end
      QFC_ST_WR_GAP: begin
        if (!tmr_busy) begin
          state_d = QFC_ST_DONE;
          if (req_q.op == qfc_pkg::QFC_OP_PROGRAM && phase_q == 2'h0) begin
            phase_d = 2'h1;
            word_d = req_q.data;
            state_d = QFC_ST_WR_SETUP;
            tmr_load = 1'b1;
            tmr_value = CW'(qfc_pkg::CS_CYC);
          end else if (req_q.op == qfc_pkg::QFC_OP_PROGRAM && phase_q == 2'h1) begin
            phase_d = 2'h2;
            state_d = QFC_ST_INTERVAL;
            tmr_load = 1'b1;
            tmr_value = CW'(qfc_pkg::DP_CYC);
          end else if (req_q.op == qfc_pkg::QFC_OP_ERASE && phase_q == 2'h0) begin
            phase_d = 2'h1;
            state_d = QFC_ST_INTERVAL;
            tmr_load = 1'b1;
            tmr_value = CW'(ERASE_CYCLES);
          end
        end
      end
      QFC_ST_INTERVAL: begin
        if (!tmr_busy) begin
          phase_d = 2'h3;
          word_d = (req_q.op == qfc_pkg::QFC_OP_ERASE) ?
                   lane_word(ERASE_STOP_CODE, req_q.lanes) :
                   lane_word(PROG_STOP_CODE, req_q.lanes);
          state_d = QFC_ST_WR_SETUP;
          tmr_load = 1'b1;
          tmr_value = CW'(qfc_pkg::CS_CYC);
        end
      end
      QFC_ST_RD_WAIT: begin
        if (!rec_busy) begin
          state_d = QFC_ST_RD_ACCESS;
          tmr_load = 1'b1;
          tmr_value = CW'(ACCESS_CYCLES + qfc_pkg::SYNC_STAGES);
        end
      end
      QFC_ST_RD_ACCESS: begin
        // The pins stay selected until the synchronised data has settled.
        if (!tmr_busy) begin
          rdata_d = sync_q[qfc_pkg::SYNC_STAGES-1];
          rvalid_d = 1'b1;
          state_d = QFC_ST_RD_DONE;
        end
      end
      QFC_ST_RD_DONE: begin
        state_d = QFC_ST_IDLE;
      end
      QFC_ST_DONE: begin
        state_d = QFC_ST_IDLE;
      end
      default: begin
        state_d = QFC_ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Pin image, registered so every pin leaves a flip-flop.
  // ************************************************************
  always_comb begin
    pins_d.addr = req_d.addr;
    pins_d.dout = word_d;
    pins_d.dout_oe = 1'b0;
    pins_d.sel_n = 1'b1;
    pins_d.we_n = 1'b1;
    pins_d.oe_n = 1'b1;
    pins_d.vpp = 1'b0;
    case (state_d)
      QFC_ST_WR_SETUP, QFC_ST_WR_HOLD: begin
        pins_d.sel_n = 1'b0;
        pins_d.dout_oe = 1'b1;
      end
      QFC_ST_WR_PULSE: begin
        pins_d.sel_n = 1'b0;
        pins_d.we_n = 1'b0;
        pins_d.dout_oe = 1'b1;
      end
      QFC_ST_RD_ACCESS: begin
        pins_d.sel_n = 1'b0;
        pins_d.oe_n = 1'b0;
      end
      default: begin
        pins_d.sel_n = 1'b1;
      end
    endcase
    // The supply stays up from the lead-in to the end of the stop write.
    if (req_d.op == qfc_pkg::QFC_OP_PROGRAM || req_d.op == qfc_pkg::QFC_OP_ERASE) begin
      if (state_d != QFC_ST_IDLE && state_d != QFC_ST_DONE) begin
        pins_d.vpp = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state_q <= QFC_ST_IDLE;
      req_q <= '0;
      phase_q <= 2'h0;
      word_q <= '0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      pins_q <= '{addr: '0, dout: '0, dout_oe: 1'b0, sel_n: 1'b1, we_n: 1'b1,
                  oe_n: 1'b1, vpp: 1'b0};
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      phase_q <= phase_d;
      word_q <= word_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      pins_q <= pins_d;
    end
  end

  // Read data arrives from the pins, outside the clock's timing, so it
  // passes two flip-flops before the capture reads it.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      for (int i = 0; i < qfc_pkg::SYNC_STAGES; i++) begin
        sync_q[i] <= '0;
      end
    end else begin
      sync_q[0] <= MODULE_DATA_LINES_I;
      for (int i = 1; i < qfc_pkg::SYNC_STAGES; i++) begin
        sync_q[i] <= sync_q[i-1];
      end
    end
  end

  assign CMD_READY = (state_q == QFC_ST_IDLE);
  assign RD_VALID = rvalid_q;
  assign RD_DATA = rdata_q;
  assign WORD_ADDRESS_LINES = pins_q.addr;
  assign MODULE_DATA_LINES_O = pins_q.dout;
  assign MODULE_DATA_LINES_OE = pins_q.dout_oe;
  assign PAIR_SELECT_LOW_N = pins_q.sel_n;
  assign PAIR_SELECT_HIGH_N = pins_q.sel_n;
  assign PAIR_WRITE_STROBE_LOW_N = pins_q.we_n;
  assign PAIR_WRITE_STROBE_HIGH_N = pins_q.we_n;
  assign OUTPUT_ENABLE_N = pins_q.oe_n;
  assign VPP_ENABLE = pins_q.vpp;

endmodule

// [tb/qfc_seq_chk_sva.sv]
/*
 * Checker for the quad flash sequencer, bound to its top module ports.
 * Assumes the sequencer drives both selects and both strobes together.
 */
`timescale 1ns/1ps
module qfc_seq_chk #(
  parameter int ERASE_CYCLES = qfc_pkg::DE_NOM_CYC
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PAIR_SELECT_LOW_N,
  input wire logic PAIR_SELECT_HIGH_N,
  input wire logic PAIR_WRITE_STROBE_LOW_N,
  input wire logic PAIR_WRITE_STROBE_HIGH_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic [qfc_pkg::DATA_W-1:0] MODULE_DATA_LINES_O,
  input wire logic MODULE_DATA_LINES_OE,
  input wire logic VPP_ENABLE
);
  localparam int SLACK = 40;
  localparam int SAT = 1 << 30;
  // ************************************************************
  // Helper counters.
  // ************************************************************
  int gap_q, gap_d, vpp_q, vpp_d;
  logic [1:0] wnum_q, wnum_d;
  logic prog_q, prog_d, we_q;
  logic fall;
  logic [3:0] is_setup;
  assign fall = we_q && !PAIR_WRITE_STROBE_LOW_N;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      is_setup[i] = MODULE_DATA_LINES_O[8*i +: 8] == qfc_pkg::PROG_SETUP_CODE;
    end
    gap_d = PAIR_WRITE_STROBE_LOW_N ? ((gap_q < SAT) ? gap_q + 1 : gap_q) : 0;
    vpp_d = VPP_ENABLE ? ((vpp_q < SAT) ? vpp_q + 1 : vpp_q) : 0;
    wnum_d = !VPP_ENABLE ? 2'h0 : (fall ? wnum_q + 2'h1 : wnum_q);
    prog_d = (fall && VPP_ENABLE && wnum_q == 2'h0) ? |is_setup : prog_q;
  end
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      gap_q <= SAT;
      vpp_q <= 0;
      wnum_q <= 2'h0;
      prog_q <= 1'b0;
      we_q <= 1'b1;
    end else begin
      gap_q <= gap_d;
      vpp_q <= vpp_d;
      wnum_q <= wnum_d;
      prog_q <= prog_d;
      we_q <= PAIR_WRITE_STROBE_LOW_N;
    end
  end
  function automatic logic lanes_ok(input logic [31:0] w);
    logic [7:0] c;
    logic ok;
    c = w[7:0] | w[15:8] | w[23:16] | w[31:24];
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      ok = ok && (w[8*i +: 8] == 8'h00 || w[8*i +: 8] == c);
    end
    return ok;
  endfunction
  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // The pulse must cover the minimum width and end soon after; the sequencer
  // may stretch it by a cycle of timer latency.
  sequence strobe_pulse_s;
    !PAIR_WRITE_STROBE_LOW_N [*8] ##[1:4] PAIR_WRITE_STROBE_LOW_N;
  endsequence
  sequence strobe_start_s;
    $fell(PAIR_WRITE_STROBE_LOW_N);
  endsequence
  select_pair_a: assert property (
    PAIR_SELECT_LOW_N == PAIR_SELECT_HIGH_N &&
    PAIR_WRITE_STROBE_LOW_N == PAIR_WRITE_STROBE_HIGH_N)
    else $error("pair pins differ");
  strobe_in_select_a: assert property (
    !PAIR_WRITE_STROBE_LOW_N |->
    (!PAIR_SELECT_LOW_N && !$past(PAIR_SELECT_LOW_N)) ##1 !PAIR_SELECT_LOW_N)
    else $error("strobe outside select");
  strobe_width_a: assert property (
    strobe_start_s |-> strobe_pulse_s)
    else $error("strobe width wrong");
  data_held_a: assert property (
    !PAIR_WRITE_STROBE_LOW_N |-> MODULE_DATA_LINES_OE && $stable(MODULE_DATA_LINES_O))
    else $error("write data moved");
  no_contend_a: assert property (
    !OUTPUT_ENABLE_N |-> !MODULE_DATA_LINES_OE)
    else $error("host drives during read");
  read_recovery_a: assert property (
    $fell(OUTPUT_ENABLE_N) |-> gap_q >= qfc_pkg::WR_CYC)
    else $error("read too soon after write");
  vpp_setup_a: assert property (
    $fell(PAIR_SELECT_LOW_N) && VPP_ENABLE |-> vpp_q >= qfc_pkg::VPEL_CYC)
    else $error("supply raised late");
  lane_copy_a: assert property (
    strobe_start_s ##0 (VPP_ENABLE && wnum_q == 2'h0) |-> lanes_ok(MODULE_DATA_LINES_O))
    else $error("command lanes not copies");
  prog_time_a: assert property (
    strobe_start_s ##0 (VPP_ENABLE && prog_q && wnum_q == 2'h2) |->
    gap_q >= qfc_pkg::DP_CYC)
    else $error("program interval short");
  erase_time_a: assert property (
    strobe_start_s ##0 (VPP_ENABLE && !prog_q && wnum_q == 2'h1) |->
    gap_q >= ERASE_CYCLES && gap_q <= ERASE_CYCLES + SLACK)
    else $error("erase interval off");
endmodule
bind qfc_sequencer qfc_seq_chk #(.ERASE_CYCLES(ERASE_CYCLES)) qfc_seq_chk_i (
  .REF_CLK(REF_CLK), .RESET(RESET), .PAIR_SELECT_LOW_N(PAIR_SELECT_LOW_N),
  .PAIR_SELECT_HIGH_N(PAIR_SELECT_HIGH_N), .PAIR_WRITE_STROBE_LOW_N(PAIR_WRITE_STROBE_LOW_N),
  .PAIR_WRITE_STROBE_HIGH_N(PAIR_WRITE_STROBE_HIGH_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
  .MODULE_DATA_LINES_O(MODULE_DATA_LINES_O), .MODULE_DATA_LINES_OE(MODULE_DATA_LINES_OE),
  .VPP_ENABLE(VPP_ENABLE));

// [tb/qfc_flash_model.sv]
/*
 * Behavioural model of the four-lane flash module seen from its pins.
 * Assumes the bench resolves the shared data bus from both drivers.
 */
`timescale 1ns/1ps
module qfc_flash_model #(
  parameter logic [7:0] ERASE_CODE = 8'h20
) (
  input wire logic sel_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic vpp,
  input wire logic [16:0] addr,
  input wire logic [31:0] din,
  output logic [31:0] dout
);
  logic [31:0] mem [logic [16:0]];
  logic [1:0] st [4];
  logic [31:0] shown;
  initial begin
    foreach (st[i]) st[i] = 2'h0;
    dout = 32'h0;
    shown = 32'h0;
  end
  function automatic logic [31:0] word(input logic [16:0] a);
    return mem.exists(a) ? mem[a] : 32'hffffffff;
  endfunction
  // Each lane keeps its own command state, since idle lanes see zero bytes.
  always @(posedge we_n) begin
    if (!sel_n) begin
      for (int i = 0; i < 4; i++) begin
        logic [7:0] b;
        logic [31:0] m;
        b = din[8*i +: 8];
        case (st[i])
          2'h0: st[i] = (b == 8'h40 && vpp) ? 2'h1 : ((b == ERASE_CODE && vpp) ? 2'h3 : 2'h0);
          2'h1: begin
            m = word(addr);
            m[8*i +: 8] = b;
            mem[addr] = m;
            st[i] = 2'h2;
          end
          2'h2: st[i] = 2'h0;
          default: begin
            foreach (mem[a]) mem[a][8*i +: 8] = 8'hff;
            st[i] = 2'h0;
          end
        endcase
      end
    end
  end
  // A released bus shows the inverse of the last read word so a stale value cannot pass.
  always @(sel_n or oe_n or addr or we_n) begin
    if (!sel_n && !oe_n) begin
      dout = word(addr);
      shown = dout;
    end else begin
      // Inverted from the last shown word, so repeated pin events keep it inverted.
      dout = ~shown;
    end
  end
endmodule

// [tb/quad_flash_command_access_tb.sv]
/*
 * Self-checking bench for the quad flash sequencer against a pin-level model.
 * Assumes a 100 MHz clock and a shortened erase interval.
 */
`timescale 1ns/1ps
module quad_flash_command_access_tb;
  localparam int ERASE_CYC = 50;
  logic REF_CLK, RESET, CMD_VALID, CMD_READY, RD_VALID, DATA_OE, OE_N, VPP;
  logic SEL_L, SEL_H, WE_L, WE_H;
  qfc_pkg::qfc_req_s CMD_REQ;
  logic [31:0] RD_DATA, DQ_O, DQ_I, MODEL_DQ;
  logic [16:0] ADDR;
  logic [16:0] full_ad;
  logic [31:0] exp_q[$];
  logic [31:0] shadow [logic [16:0]];
  logic [31:0] rnd;
  int errors, checks_done, cycles;
  assign DQ_I = DATA_OE ? DQ_O : MODEL_DQ;
  qfc_sequencer #(.ERASE_CYCLES(ERASE_CYC)) qfc_sequencer_i (
    .REF_CLK(REF_CLK), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
    .CMD_REQ(CMD_REQ), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .WORD_ADDRESS_LINES(ADDR),
    .MODULE_DATA_LINES_O(DQ_O), .MODULE_DATA_LINES_OE(DATA_OE), .MODULE_DATA_LINES_I(DQ_I),
    .PAIR_SELECT_LOW_N(SEL_L), .PAIR_SELECT_HIGH_N(SEL_H), .PAIR_WRITE_STROBE_LOW_N(WE_L),
    .PAIR_WRITE_STROBE_HIGH_N(WE_H), .OUTPUT_ENABLE_N(OE_N), .VPP_ENABLE(VPP));
  qfc_flash_model qfc_flash_model_i (
    .sel_n(SEL_L), .we_n(WE_L), .oe_n(OE_N), .vpp(VPP), .addr(ADDR), .din(DQ_O),
    .dout(MODEL_DQ));
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // ************************************************************
  // Shared tasks.
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] lane_mask(input logic [3:0] ln);
    return {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
  endfunction
  task automatic compare_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic send(input qfc_pkg::qfc_op_e op, input logic [3:0] ln, input logic [7:0] cd,
                      input logic [16:0] ad, input logic [31:0] dt);
    @(posedge REF_CLK);
    CMD_VALID <= 1'b1;
    CMD_REQ <= '{op, ln, cd, ad, dt};
    do @(posedge REF_CLK); while (CMD_READY !== 1'b1);
    CMD_VALID <= 1'b0;
  endtask
  task automatic read_back(input logic [16:0] ad);
    exp_q.push_back(shadow.exists(ad) ? shadow[ad] : 32'hffffffff);
    send(qfc_pkg::QFC_OP_READ, 4'h0, 8'h00, ad, 32'h0);
  endtask
  task automatic write_prog(input logic [3:0] ln, input logic [16:0] ad, input logic [31:0] dt);
    logic [31:0] old;
    old = shadow.exists(ad) ? shadow[ad] : 32'hffffffff;
    shadow[ad] = (old & ~lane_mask(ln)) | (dt & lane_mask(ln));
    send(qfc_pkg::QFC_OP_PROGRAM, ln, qfc_pkg::PROG_SETUP_CODE, ad, dt & lane_mask(ln));
  endtask
  // ************************************************************
  // Result watcher and timeout.
  // ************************************************************
  always @(posedge REF_CLK) begin
    if (RD_VALID === 1'b1) begin
      if (exp_q.size() == 0) compare_word(RD_DATA, 32'hx, "unexpected read");
      else compare_word(RD_DATA, exp_q.pop_front(), "read word");
    end
  end
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      close_out();
    end
  end
  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    CMD_VALID = 1'b0;
    CMD_REQ = '0;
    RESET = 1'b1;
    rnd = 32'h30;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (2) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    compare_word({24'h0, SEL_L, SEL_H, WE_L, WE_H, OE_N, VPP, DATA_OE, CMD_READY},
                 32'hf9, "idle pins");
    $display("test reset done");
    read_back(17'h00010);
    $display("test erased read done");
    rnd = lfsr(rnd);
    full_ad = rnd[16:0];
    write_prog(4'hf, full_ad, lfsr(rnd));
    read_back(full_ad);
    $display("test full program done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(lfsr(rnd));
      write_prog(4'h1 << i, 17'h00123, rnd & 32'h7f7f7f7f);
      read_back(17'h00123);
    end
    $display("test single lane program done");
    foreach (shadow[a]) shadow[a] = shadow[a] | 32'h0000ffff;
    send(qfc_pkg::QFC_OP_ERASE, 4'h3, 8'h20, 17'h0, 32'h0);
    read_back(17'h00123);
    read_back(full_ad);
    $display("test erase done");
    send(qfc_pkg::QFC_OP_WRITE, 4'hf, 8'h00, 17'h00123, 32'h0);
    read_back(17'h00123);
    $display("test write then read done");
    for (int n = 0; n < 2000 && exp_q.size() != 0; n++) @(posedge REF_CLK);
    compare_word(32'(exp_q.size()), 32'h0, "reads outstanding");
    close_out();
  end
endmodule
